/* hw/pali_alarm_latch.sv */
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pali_alarm_latch #(
    parameter int unsigned FLASH_HALF_CYC = pali_pkg::FLASH_HALF_CYC,
    parameter int DW = 16
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic signed [DW-1:0] PROC_VALUE_I,
    input wire logic signed [DW-1:0] SETPOINT_I,
    input wire logic [DW-1:0] LOAD_CURRENT_I,
    input wire logic [DW-1:0] LEAKAGE_CURRENT_I,
    input wire logic DIG_IN1_I,
    input wire logic DIG_IN2_I,
    input wire logic PAGE_KEY_I,
    input wire logic FUNCTION_KEY_ONE_I,
    input wire logic FUNCTION_KEY_TWO_I,
    output logic [5:0] ALARM_OUT_O,
    output logic ALARM_BEACON_O,
    output logic [2:0] ALARM_NUM_O,
    output logic ALARM_NUM_SHOW_O
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic ct_en;
        logic level2;
        logic [2:0][2:0] atype;
        logic [3:0][1:0] lmode;
        logic [5:0] pol;
        logic [4:0] src_en;
        logic [5:0][DW-1:0] thr;
        logic [5:0] active;
        logic [5:0] acked;
        logic [5:0] out;
        logic [31:0] div;
        logic phase;
        logic [2:0] idx;
        logic beacon;
        logic [2:0] num;
        logic num_show;
        logic [31:0] rdata;
    } pali_state_s;

    pali_state_s s_q;
    pali_state_s s_d;

    logic [5:0] cond;
    logic [5:0] ack_i;
    logic ack_hw;
    logic param_ack;
    logic ack_visible;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_val;
    logic signed [DW:0] pv_x;
    logic signed [DW:0] sp_x;
    logic signed [DW:0] diff;
    logic signed [DW:0] thr_x;
    logic [1:0] m;
    logic [1:0] m_ack;
    logic ak;
    logic found;
    logic [2:0] j;
    logic period_end;

    ////////////////////////////////////////////////////////////////////////
    // Alarm conditions from process value and load currents.
    always_comb begin
        cond = '0;
        pv_x = {PROC_VALUE_I[DW-1], PROC_VALUE_I};
        sp_x = {SETPOINT_I[DW-1], SETPOINT_I};
        diff = pv_x - sp_x;
        thr_x = '0;
        for (int i = 0; i < pali_pkg::N_PROC; i++) begin
            thr_x = {s_q.thr[i][DW-1], s_q.thr[i]};
            unique case (s_q.atype[i])
                pali_pkg::TYPE_ABS_LOW: cond[i] = pv_x < thr_x;
                pali_pkg::TYPE_ABS_HIGH: cond[i] = pv_x > thr_x;
                pali_pkg::TYPE_DEV_LOW: cond[i] = -diff > thr_x;
                pali_pkg::TYPE_DEV_HIGH: cond[i] = diff > thr_x;
                pali_pkg::TYPE_DEV_BAND: cond[i] = (diff > thr_x) ||
                    (-diff > thr_x);
                default: cond[i] = 1'b0;
            endcase
        end
        // A load that draws too little current means a failed heater.
        cond[3] = s_q.ct_en && (LOAD_CURRENT_I < s_q.thr[3]);
        cond[4] = s_q.ct_en && (LEAKAGE_CURRENT_I > s_q.thr[4]);
        cond[5] = s_q.ct_en && (LOAD_CURRENT_I > s_q.thr[5]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode; read data is captured in the setup cycle so that
    // the slave answers with no wait state and data comes from a flop.
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        unique case (PADDR_I)
            pali_pkg::OFS_CTRL: begin
                rd_val[pali_pkg::CTRL_CT_EN] = s_q.ct_en;
                rd_val[pali_pkg::CTRL_LEVEL2] = s_q.level2;
            end
            pali_pkg::OFS_TYPE: rd_val[8:0] = s_q.atype;
            pali_pkg::OFS_LATCH: rd_val[7:0] = s_q.lmode;
            pali_pkg::OFS_POL: rd_val[5:0] = s_q.pol;
            pali_pkg::OFS_ACK_SRC: rd_val[4:0] = s_q.src_en;
            pali_pkg::OFS_ACK: rd_val[pali_pkg::ACK_CONFIRM] = ack_visible;
            pali_pkg::OFS_STATUS: begin
                rd_val[5:0] = s_q.active;
                rd_val[pali_pkg::STAT_ACKED +: 6] = s_q.acked;
                rd_val[pali_pkg::STAT_COND +: 6] = cond;
                rd_val[pali_pkg::STAT_NUM +: 3] = s_q.num;
            end
            default: begin
                mapped = 1'b0;
                for (int k = 0; k < pali_pkg::N_ALARM; k++) begin
                    if (PADDR_I == pali_pkg::OFS_THR_BASE + 8'(4 * k)) begin
                        rd_val[DW-1:0] = s_q.thr[k];
                        mapped = 1'b1;
                    end
                end
            end
        endcase
    end

    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && mapped;
    assign PREADY_O = PSEL_I && PENABLE_I;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge sources merged into one pulse per cycle.
    always_comb begin
        m_ack = pali_pkg::LATCH_NONE;
        // Hidden at level 2 once any key is assigned to acknowledge.
        ack_visible = !(s_q.level2 && (|s_q.src_en[4:2]));
        param_ack = wr_en && (PADDR_I == pali_pkg::OFS_ACK) && ack_visible &&
            (PWDATA_I[pali_pkg::ACK_CONFIRM] == pali_pkg::CONFIRM_YES);
        // Rising edges of synchronised pins, only where enabled.
        ack_hw = |(s_q.s2 & ~s_q.s3 & s_q.src_en);
        for (int i = 0; i < pali_pkg::N_ALARM; i++) begin
            m_ack = s_q.lmode[(i < pali_pkg::N_PROC) ? i : pali_pkg::N_PROC];
            // At level 1 the parameter reaches latching alarms only.
            ack_i[i] = ack_hw || (param_ack && (s_q.level2 ||
                m_ack != pali_pkg::LATCH_NONE));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: registers, latches, outputs and display sequencing.
    always_comb begin
        s_d = s_q;
        ak = 1'b0;
        found = 1'b0;
        j = 3'h0;
        period_end = 1'b0;
        m = pali_pkg::LATCH_NONE;
        s_d.s1 = {FUNCTION_KEY_TWO_I, FUNCTION_KEY_ONE_I, PAGE_KEY_I,
            DIG_IN2_I, DIG_IN1_I};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (PSEL_I && !PENABLE_I) begin
            s_d.rdata = rd_val;
        end
        if (wr_en) begin
            unique case (PADDR_I)
                pali_pkg::OFS_CTRL: begin
                    s_d.ct_en = PWDATA_I[pali_pkg::CTRL_CT_EN];
                    s_d.level2 = PWDATA_I[pali_pkg::CTRL_LEVEL2];
                end
                pali_pkg::OFS_TYPE: s_d.atype = PWDATA_I[8:0];
                pali_pkg::OFS_LATCH: s_d.lmode = PWDATA_I[7:0];
                pali_pkg::OFS_POL: s_d.pol = PWDATA_I[5:0];
                pali_pkg::OFS_ACK_SRC: s_d.src_en = PWDATA_I[4:0];
                default: begin
                    for (int k = 0; k < pali_pkg::N_ALARM; k++) begin
                        if (PADDR_I ==
                            pali_pkg::OFS_THR_BASE + 8'(4 * k)) begin
                            s_d.thr[k] = PWDATA_I[DW-1:0];
                        end
                    end
                end
            endcase
        end
        // Each latch sees only its own condition; alarms 3 to 5 share one mode.
        for (int i = 0; i < pali_pkg::N_ALARM; i++) begin
            m = s_q.lmode[(i < pali_pkg::N_PROC) ? i : pali_pkg::N_PROC];
            ak = s_q.acked[i] || ack_i[i];
            unique case (m)
                pali_pkg::LATCH_AUTO: begin
                    if (!s_q.active[i]) begin
                        s_d.active[i] = cond[i];
                        s_d.acked[i] = 1'b0;
                    end else if (ak && !cond[i]) begin
                        s_d.active[i] = 1'b0;
                        s_d.acked[i] = 1'b0;
                    end else begin
                        s_d.acked[i] = ak;
                    end
                end
                pali_pkg::LATCH_MANUAL: begin
                    if (!s_q.active[i]) begin
                        s_d.active[i] = cond[i];
                        s_d.acked[i] = 1'b0;
                    end else if (!cond[i] && ack_i[i]) begin
                        s_d.active[i] = 1'b0;
                        s_d.acked[i] = 1'b0;
                    end else begin
                        // Early acknowledge only steadies the beacon.
                        s_d.acked[i] = s_q.acked[i] ||
                            (ack_i[i] && cond[i]);
                    end
                end
                default: begin
                    s_d.active[i] = cond[i];
                    s_d.acked[i] = cond[i] && ak;
                end
            endcase
            // Polarity 0 drops the output in alarm, so power loss alarms too.
            s_d.out[i] = s_q.pol[i] ? s_d.active[i] : !s_d.active[i];
        end
        // Free-running flash divider.
        if (s_q.div >= FLASH_HALF_CYC - 1) begin
            s_d.div = 32'h0000_0000;
            s_d.phase = !s_q.phase;
            period_end = s_q.phase;
        end else begin
            s_d.div = s_q.div + 32'h0000_0001;
        end
        // Step to the next active alarm after the one shown.
        if (period_end || !s_d.active[s_q.idx]) begin
            for (int k = 1; k <= pali_pkg::N_ALARM; k++) begin
                j = 3'((32'(s_q.idx) + 32'(k)) % pali_pkg::N_ALARM);
                if (!found && s_d.active[j]) begin
                    s_d.idx = j;
                    found = 1'b1;
                end
            end
        end
        s_d.num = s_d.active[s_d.idx] ? s_d.idx + 3'h1 : 3'h0;
        s_d.num_show = s_d.active[s_d.idx] && s_d.phase;
        // Beacon flashes while anything is unacknowledged, else steady.
        if (|(s_d.active & ~s_d.acked)) begin
            s_d.beacon = s_d.phase;
        end else begin
            s_d.beacon = |s_d.active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; defaults give non-latching, de-energised in alarm.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            s_q <= '0;
            s_q.atype <= pali_pkg::RST_TYPE;
            s_q.lmode <= pali_pkg::RST_LATCH;
            s_q.pol <= pali_pkg::RST_POL;
            s_q.out <= 6'h3F;
        end else begin
            s_q <= s_d;
        end
    end

    assign ALARM_OUT_O = s_q.out;
    assign ALARM_BEACON_O = s_q.beacon;
    assign ALARM_NUM_O = s_q.num;
    assign ALARM_NUM_SHOW_O = s_q.num_show;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    property p_thr_write;
        wr_en && PADDR_I == pali_pkg::OFS_THR_BASE |=>
            s_q.thr[0] == $past(PWDATA_I[DW-1:0]);
    endproperty
    a_thr_write: assert property (p_thr_write)
        else $error("Threshold write not stored.");

    property p_out_pol;
        ##1 ALARM_OUT_O == ~(s_q.active ^ $past(s_q.pol));
    endproperty
    a_out_pol: assert property (p_out_pol)
        else $error("Alarm output disagrees with polarity.");

    property p_none_clear;
        s_q.lmode[0] == pali_pkg::LATCH_NONE && !cond[0] |=> !s_q.active[0];
    endproperty
    a_none_clear: assert property (p_none_clear)
        else $error("Non-latching alarm did not clear.");

    property p_manual_hold;
        s_q.lmode[0] == pali_pkg::LATCH_MANUAL && s_q.active[0] && cond[0]
            |=> s_q.active[0];
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("Manual alarm cleared while present.");

    property p_auto_hold;
        s_q.lmode[0] == pali_pkg::LATCH_AUTO && s_q.active[0] &&
            !s_q.acked[0] && !ack_i[0] |=> s_q.active[0];
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("Auto alarm cleared without acknowledge.");

    property p_auto_release;
        s_q.lmode[0] == pali_pkg::LATCH_AUTO && s_q.acked[0] && !cond[0]
            |=> !s_q.active[0];
    endproperty
    a_auto_release: assert property (p_auto_release)
        else $error("Acknowledged auto alarm did not clear.");

    property p_quiet;
        s_q.active == 6'h00 |-> !ALARM_BEACON_O && ALARM_NUM_O == 3'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Beacon or number shown with no alarm.");

    property p_steady;
        s_q.active != 6'h00 && (s_q.active & ~s_q.acked) == 6'h00
            |-> ALARM_BEACON_O;
    endproperty
    a_steady: assert property (p_steady)
        else $error("Acknowledged beacon is not steady.");

    property p_ack_pulse;
        ack_hw |=> !ack_hw;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("Acknowledge lasted more than one cycle.");

    // At level 1 the parameter must not reach a non-latching alarm.
    property p_level1_none;
        !s_q.level2 && s_q.lmode[0] == pali_pkg::LATCH_NONE && !ack_hw
            |-> !ack_i[0];
    endproperty
    a_level1_none: assert property (p_level1_none)
        else $error("Level 1 acknowledge reached a non-latching alarm.");
endmodule

/* shared/pali_pkg.sv */
package pali_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TYPE = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_POL = 8'h0C;
    localparam logic [7:0] OFS_ACK_SRC = 8'h10;
    localparam logic [7:0] OFS_ACK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_THR_BASE = 8'h20;
    // Field positions.
    localparam int CTRL_CT_EN = 0;
    localparam int CTRL_LEVEL2 = 1;
    localparam int ACK_CONFIRM = 0;
    localparam int STAT_ACKED = 8;
    localparam int STAT_COND = 16;
    localparam int STAT_NUM = 24;
    localparam int SRC_DIN1 = 0;
    localparam int SRC_DIN2 = 1;
    localparam int SRC_PAGE = 2;
    localparam int SRC_FKEY1 = 3;
    localparam int SRC_FKEY2 = 4;
    // Counts of alarms and acknowledge sources.
    localparam int N_ALARM = 6;
    localparam int N_PROC = 3;
    localparam int N_SRC = 5;
    localparam int N_LATCH = 4;
    // Encodings.
    localparam logic [2:0] TYPE_ABS_LOW = 3'h0;
    localparam logic [2:0] TYPE_ABS_HIGH = 3'h1;
    localparam logic [2:0] TYPE_DEV_LOW = 3'h2;
    localparam logic [2:0] TYPE_DEV_HIGH = 3'h3;
    localparam logic [2:0] TYPE_DEV_BAND = 3'h4;
    localparam logic [2:0] TYPE_OFF = 3'h7;
    localparam logic [1:0] LATCH_NONE = 2'h0;
    localparam logic [1:0] LATCH_AUTO = 2'h1;
    localparam logic [1:0] LATCH_MANUAL = 2'h2;
    localparam logic CONFIRM_YES = 1'b1;
    // Reset values.
    localparam logic [8:0] RST_TYPE = 9'h1FF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [5:0] RST_POL = 6'h00;
    // Flash timing: half period in ms, clock in MHz, derived cycles.
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
endpackage

/* test/pali_panel.sv */
`timescale 1ns/1ps
// Front panel stand-in for the keys and digital inputs: a press request
// holds its pin high for three cycles, like a real button, then the pin
// falls back to its pulled-down idle level.
module pali_panel (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] press_i,
    output logic [4:0] pins_o
);
    logic [4:0][1:0] hold_q;

    ////////////////////////////////////////////////////////////////////////
    // A held pin must still give one acknowledge only, so hold a few cycles.
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 5; i++) begin
            if (!rst_n_i) begin
                hold_q[i] <= 2'h0;
            end else if (press_i[i]) begin
                hold_q[i] <= 2'h3;
            end else if (hold_q[i] != 2'h0) begin
                hold_q[i] <= hold_q[i] - 2'h1;
            end
        end
    end

    // Pin level follows the hold counter.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pins_o[i] = (hold_q[i] != 2'h0);
        end
    end
endmodule

/* test/pali_alarm_latch_tb.sv */
`timescale 1ns/1ps
module pali_alarm_latch_tb;
    localparam int unsigned HALF = 8;
    logic clk;
    logic rst_n;
    logic psel;
    logic pen;
    logic pwr;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] pv;
    logic signed [15:0] sp;
    logic [15:0] ld;
    logic [15:0] lk;
    logic [4:0] press;
    logic [4:0] pins;
    logic [5:0] aout;
    logic beacon;
    logic [2:0] num;
    logic show;
    logic [31:0] rdv;
    logic errv;
    logic [7:0] seen;
    int errors;
    int n_checks;
    int bh;
    int sh;
    logic [15:0] pv_on [5] = '{16'h000A, 16'h0064, 16'h0032, 16'h0096,
        16'h0096};
    logic [15:0] pv_off [5] = '{16'h0064, 16'h000A, 16'h0064, 16'h0064,
        16'h0064};

    pali_alarm_latch #(.FLASH_HALF_CYC(HALF), .DW(16)) DUT (
        .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .PROC_VALUE_I(pv), .SETPOINT_I(sp), .LOAD_CURRENT_I(ld),
        .LEAKAGE_CURRENT_I(lk), .DIG_IN1_I(pins[0]), .DIG_IN2_I(pins[1]),
        .PAGE_KEY_I(pins[2]), .FUNCTION_KEY_ONE_I(pins[3]),
        .FUNCTION_KEY_TWO_I(pins[4]), .ALARM_OUT_O(aout),
        .ALARM_BEACON_O(beacon), .ALARM_NUM_O(num),
        .ALARM_NUM_SHOW_O(show));

    pali_panel panel (.clk_i(clk), .rst_n_i(rst_n), .press_i(press),
        .pins_o(pins));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run, shared by the tests and the watchdog.
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits, then samples away from the edge so no update races the read.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic chk_out(input logic [5:0] e);
        settle(6);
        chk({26'h0, aout}, {26'h0, e});
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic ack_par();
        wr(pali_pkg::OFS_ACK, 32'h0000_0001);
    endtask

    // Three edges of hold give the condition time to be seen.
    task automatic setpv(input logic [15:0] v);
        @(posedge clk);
        pv <= v;
        repeat (3) @(posedge clk);
    endtask

    task automatic tap(input int k);
        @(posedge clk);
        press[k] <= 1'b1;
        @(posedge clk);
        press <= 5'h00;
        repeat (8) @(posedge clk);
    endtask

    // Counts lit beacon and number cycles, and which numbers were shown.
    task automatic watch(input int n);
        seen = 8'h00;
        bh = 0;
        sh = 0;
        repeat (n) begin
            @(negedge clk);
            bh += int'(beacon);
            sh += int'(show);
            seen[num] = 1'b1;
        end
    endtask

    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pv = 16'h0064;
        sp = 16'h0064;
        ld = 16'h00C8;
        lk = 16'h0000;
        press = 5'h00;
        errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk_out(6'h3F);
        rd(pali_pkg::OFS_TYPE);
        chk(rdv, 32'h0000_01FF);
        rd(pali_pkg::OFS_LATCH);
        chk(rdv, 32'h0000_0000);
        rd(pali_pkg::OFS_POL);
        chk(rdv, 32'h0000_0000);
        rd(8'hFC);
        chk({rdv[30:0], errv}, 32'h0000_0001);
        wr(pali_pkg::OFS_THR_BASE, 32'h0000_0014);
        // Every condition type, asserted and then withdrawn.
        for (int t = 0; t < 5; t++) begin
            wr(pali_pkg::OFS_TYPE, 32'(t));
            setpv(pv_on[t]);
            chk_out(6'h3E);
            setpv(pv_off[t]);
            chk_out(6'h3F);
        end
        // Absolute high for the indication and polarity scenarios below.
        wr(pali_pkg::OFS_TYPE, 32'h0000_0001);
        setpv(16'h0064);
        watch(64);
        chk(32'(bh > 0 && bh < 64), 32'h0000_0001);
        chk({24'h0, seen & 8'hFE}, 32'h0000_0002);
        ack_par();
        watch(64);
        chk(32'(bh < 64), 32'h0000_0001);
        wr(pali_pkg::OFS_CTRL, 32'h0000_0002);
        ack_par();
        watch(64);
        chk(32'(bh), 32'h0000_0040);
        chk(32'(sh > 0 && sh < 64), 32'h0000_0001);
        chk_out(6'h3E);
        setpv(16'h000A);
        chk_out(6'h3F);
        chk({31'h0, beacon}, 32'h0000_0000);
        // Energised in alarm, then back to the safer polarity.
        wr(pali_pkg::OFS_POL, 32'h0000_0001);
        chk_out(6'h3E);
        setpv(16'h0064);
        chk_out(6'h3F);
        setpv(16'h000A);
        wr(pali_pkg::OFS_POL, 32'h0000_0000);
        // Automatic latching at operator level 1.
        wr(pali_pkg::OFS_CTRL, 32'h0000_0000);
        wr(pali_pkg::OFS_LATCH, 32'h0000_0001);
        setpv(16'h0064);
        setpv(16'h000A);
        chk_out(6'h3E);
        ack_par();
        chk_out(6'h3F);
        setpv(16'h0064);
        ack_par();
        chk_out(6'h3E);
        setpv(16'h000A);
        chk_out(6'h3F);
        // Manual latching acknowledged through digital input 1.
        wr(pali_pkg::OFS_CTRL, 32'h0000_0002);
        wr(pali_pkg::OFS_ACK_SRC, 32'h0000_0001);
        rd(pali_pkg::OFS_ACK);
        chk(rdv & 32'h0000_0001, 32'h0000_0001);
        wr(pali_pkg::OFS_LATCH, 32'h0000_0002);
        setpv(16'h0064);
        tap(0);
        chk_out(6'h3E);
        setpv(16'h000A);
        chk_out(6'h3E);
        tap(1);
        chk_out(6'h3E);
        tap(0);
        chk_out(6'h3F);
        // Page and function keys, each enabled alone.
        for (int k = 2; k < 5; k++) begin
            wr(pali_pkg::OFS_ACK_SRC, 32'h0000_0001 << k);
            rd(pali_pkg::OFS_ACK);
            chk(rdv & 32'h0000_0001, 32'h0000_0000);
            setpv(16'h0064);
            setpv(16'h000A);
            chk_out(6'h3E);
            tap(k);
            chk_out(6'h3F);
        end
        // Two alarms at once, then different latch modes side by side.
        wr(pali_pkg::OFS_ACK_SRC, 32'h0000_0000);
        wr(pali_pkg::OFS_LATCH, 32'h0000_0000);
        wr(pali_pkg::OFS_THR_BASE + 8'h04, 32'h0000_0032);
        wr(pali_pkg::OFS_TYPE, 32'h0000_0009);
        setpv(16'h0064);
        chk_out(6'h3C);
        watch(256);
        chk({24'h0, seen & 8'hFE}, 32'h0000_0006);
        wr(pali_pkg::OFS_LATCH, 32'h0000_0001);
        setpv(16'h000A);
        chk_out(6'h3E);
        ack_par();
        chk_out(6'h3F);
        // Load and leakage alarms once current measurement is on.
        wr(pali_pkg::OFS_TYPE, 32'h0000_01FF);
        wr(pali_pkg::OFS_THR_BASE + 8'h0C, 32'h0000_0064);
        wr(pali_pkg::OFS_THR_BASE + 8'h10, 32'h0000_0032);
        wr(pali_pkg::OFS_THR_BASE + 8'h14, 32'h0000_FFFF);
        wr(pali_pkg::OFS_CTRL, 32'h0000_0003);
        chk_out(6'h3F);
        @(posedge clk);
        lk <= 16'h0050;
        chk_out(6'h2F);
        @(posedge clk);
        ld <= 16'h000A;
        chk_out(6'h27);
        complete_run();
    end
endmodule
